/* rtl/pcb_loader.sv */
// Purpose: Profiling control block loader with event counting and ring
// Assumes: AXI4-Lite slave window holds the control block image
// Notes:   Load sanitises the image in one cycle and writes it back
//
// What this block does
// - Value sample interval n stores a record after n+1 samples.
// - Negative value sample interval loads as zero and writes zero back.
// - Only value sample may go below the minimum; others clamp to it.
// - Signed counters; negative start loads zero; save stores count.
// - Retired instruction interval n stores a record after n+1 events.
// - Negative or small retired interval becomes minimum, written back.
// - Events three upward use the same interval and counter handling.
// - Load reads the flags word to pick events and threshold interrupts.
// - Flags written back with unavailable feature bits cleared.
// - Flag bits 1 to 6 enable the six events in order.
// - Bit 29 continuous mode stores and advances head on overflow.
// - Continuous only when bit set and available, else synchronized.
// - Flag 30 with timestamp available stores timestamp, otherwise zero.
// - Flag 31 enables threshold interrupts on ring fill level.
// - After each head advance, used space at threshold raises interrupt.
// - Synchronized mode full ring keeps head and counts a missed event.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module pcb_loader
    import pcb_pkg::*;
#(
    parameter int                  NUM_EV       = 6,
    parameter logic [FIELD_W-1:0]  MIN_INTERVAL = MIN_INTERVAL_DEF,
    parameter bit                  CONTINUOUS_MODE_BIT_AVAIL   = 1'b1,
    parameter bit                  PERF_TIMESTAMP_BIT_AVAIL   = 1'b1,
    parameter bit                  INT_AVAIL    = 1'b1
) (
    input  wire logic                        ref_clk_in,    // Core clock
    input  wire logic                        arst_n_in,     // Async reset
    input  wire logic [pcb_pkg::ADDR_W-1:0]  s_axi_awaddr,  // Write address
    input  wire logic                        s_axi_awvalid, // Addr valid
    output logic                             s_axi_awready, // Addr ready
    input  wire logic [pcb_pkg::DATA_W-1:0]  s_axi_wdata,   // Write data
    input  wire logic [3:0]                  s_axi_wstrb,   // Byte enables
    input  wire logic                        s_axi_wvalid,  // Data valid
    output logic                             s_axi_wready,  // Data ready
    output logic [1:0]                       s_axi_bresp,   // Write resp
    output logic                             s_axi_bvalid,  // Resp valid
    input  wire logic                        s_axi_bready,  // Resp ready
    input  wire logic [pcb_pkg::ADDR_W-1:0]  s_axi_araddr,  // Read address
    input  wire logic                        s_axi_arvalid, // Addr valid
    output logic                             s_axi_arready, // Addr ready
    output logic [pcb_pkg::DATA_W-1:0]       s_axi_rdata,   // Read data
    output logic [1:0]                       s_axi_rresp,   // Read resp
    output logic                             s_axi_rvalid,  // Data valid
    input  wire logic                        s_axi_rready,  // Data ready
    input  wire logic [NUM_EV-1:0]           ev_in,         // Event pulses
    input  wire logic [pcb_pkg::DATA_W-1:0]  perf_timestamp_bit_in,       // Timestamp
    output logic                             rec_valid_out, // Record pulse
    output logic [pcb_pkg::ID_W-1:0]         rec_id_out,    // Record event
    output logic [pcb_pkg::DATA_W-1:0]       rec_ts_out,    // Record stamp
    output logic [pcb_pkg::DATA_W-1:0]       rec_offset_out, // Record slot
    output logic                             active_out,    // Profiling on
    output logic                             irq_out        // Interrupt
);
    typedef struct packed {
        logic                            awready;
        logic                            wready;
        logic                            aw_got;
        logic                            w_got;
        logic [ADDR_W-1:0]               awaddr;
        logic [DATA_W-1:0]               wdata;
        logic [3:0]                      wstrb;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            arready;
        logic                            rvalid;
        logic [1:0]                      rresp;
        logic [DATA_W-1:0]               rdata;
        logic                            active;
        logic [DATA_W-1:0]               flags;
        logic [DATA_W-1:0]               ring_size;
        logic [DATA_W-1:0]               tail;
        logic [DATA_W-1:0]               head;
        logic [DATA_W-1:0]               thresh;
        logic [2*DATA_W-1:0]             missed;
        logic [IST_W-1:0]                ist;
        logic [IST_W-1:0]                imask;
        logic [NUM_EV-1:0][DATA_W-1:0]   intv;
        logic [NUM_EV-1:0][DATA_W-1:0]   ctr;
        logic [NUM_EV-1:0][FIELD_W-1:0]  cnt;
        logic                            rec_valid;
        logic [ID_W-1:0]                 rec_id;
        logic [DATA_W-1:0]               rec_ts;
        logic [DATA_W-1:0]               rec_offset;
        logic                            irq;
    } pcb_state_t;

    pcb_state_t                  s;
    pcb_state_t                  n;
    logic [NUM_EV-1:0][DATA_W-1:0] clean_intv;
    logic [NUM_EV-1:0][DATA_W-1:0] clean_ctr;
    logic [DATA_W-1:0]           next_head;
    logic                        ring_full;
    logic                        thr_hit;
    logic                        load_req;
    logic                        rec_fire;
    logic [NUM_EV-1:0]           hit;
    logic [ID_W-1:0]             sel_id;
    logic [IST_W-1:0]            ist_clr;
    logic [DATA_W-1:0]           avail;

    // Bit mask of the flags that this implementation can honour
    function automatic logic [DATA_W-1:0] avail_mask();
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_EV; i++)
            m[FLG_VAL+i] = 1'b1;
        m[FLG_CONTINUOUS_MODE_BIT] = CONTINUOUS_MODE_BIT_AVAIL;
        m[FLG_PERF_TIMESTAMP_BIT] = PERF_TIMESTAMP_BIT_AVAIL;
        m[FLG_INT]  = INT_AVAIL;
        return m;
    endfunction : avail_mask

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [3:0]        strb
    );
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = new_w[8*b +: 8];
        return r;
    endfunction : merge

    // Event slot of an address, NUM_EV when outside the specifier area
    function automatic int evt_index(input logic [ADDR_W-1:0] a);
        int k;
        k = NUM_EV;
        if (a >= A_EVT_BASE)
            k = int'((a - A_EVT_BASE) >> EVT_SHIFT);
        if (k > NUM_EV)
            k = NUM_EV;
        return k;
    endfunction : evt_index

    for (genvar g = 0; g < NUM_EV; g++) begin : g_clean
        pcb_sanitise #(
            .IS_VALUE_SAMPLE (g == 0)
        ) u_clean (
            .interval_in  (s.intv[g]),
            .counter_in   (s.ctr[g]),
            .min_in       (MIN_INTERVAL),
            .interval_out (clean_intv[g]),
            .counter_out  (clean_ctr[g])
        );
    end

    pcb_ring u_ring (
        .head_in    (s.head),
        .tail_in    (s.tail),
        .size_in    (s.ring_size),
        .thresh_in  (s.thresh),
        .head_out   (next_head),
        .full_out   (ring_full),
        .thresh_out (thr_hit)
    );

    always_comb begin
        int k;
        k        = NUM_EV;
        n        = s;
        avail    = avail_mask();
        load_req = 1'b0;
        ist_clr  = '0;
        hit      = '0;
        sel_id   = '0;
        rec_fire = 1'b0;
        n.rec_valid = 1'b0;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        if (s.aw_got && s.w_got) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = RESP_OKAY;
            k = evt_index(s.awaddr);
            unique case (s.awaddr)
                A_CTRL: begin
                    if (s.wstrb[0]) begin
                        load_req = s.wdata[CTL_LOAD];
                        if (s.wdata[CTL_SAVE])
                            for (int i = 0; i < NUM_EV; i++)
                                n.ctr[i] = {{(DATA_W-FIELD_W){1'b0}},
                                            s.cnt[i]};
                        if (s.wdata[CTL_STOP])
                            n.active = 1'b0;
                    end
                end
                A_FLAGS:  n.flags     = merge(s.flags, s.wdata, s.wstrb);
                A_RSIZE:  n.ring_size = merge(s.ring_size, s.wdata, s.wstrb);
                A_TAIL:   n.tail      = merge(s.tail, s.wdata, s.wstrb);
                A_THRESH: n.thresh    = merge(s.thresh, s.wdata, s.wstrb);
                A_ISTAT:  ist_clr     = s.wdata[IST_W-1:0];
                A_IMASK:  n.imask     = s.wdata[IST_W-1:0];
                A_HEAD, A_MISS_LO, A_MISS_HI: ;
                default: begin
                    if (k < NUM_EV) begin
                        if (s.awaddr[EVT_CTR_B])
                            n.ctr[k] = merge(s.ctr[k], s.wdata, s.wstrb);
                        else
                            n.intv[k] = merge(s.intv[k], s.wdata, s.wstrb);
                    end else begin
                        n.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready  = !n.w_got && !n.bvalid;

        // Read channel
        if (s.rvalid && s_axi_rready) begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end
        if (s_axi_arvalid && s.arready) begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rresp   = RESP_OKAY;
            k = evt_index(s_axi_araddr);
            unique case (s_axi_araddr)
                A_CTRL:    n.rdata = {{(DATA_W-1){1'b0}}, s.active};
                A_FLAGS:   n.rdata = s.flags;
                A_RSIZE:   n.rdata = s.ring_size;
                A_TAIL:    n.rdata = s.tail;
                A_HEAD:    n.rdata = s.head;
                A_THRESH:  n.rdata = s.thresh;
                A_MISS_LO: n.rdata = s.missed[DATA_W-1:0];
                A_MISS_HI: n.rdata = s.missed[2*DATA_W-1:DATA_W];
                A_ISTAT:   n.rdata = {{(DATA_W-IST_W){1'b0}}, s.ist};
                A_IMASK:   n.rdata = {{(DATA_W-IST_W){1'b0}}, s.imask};
                default: begin
                    if (k < NUM_EV) begin
                        n.rdata = s_axi_araddr[EVT_CTR_B] ? s.ctr[k]
                                                          : s.intv[k];
                    end else begin
                        n.rdata = '0;
                        n.rresp = RESP_SLVERR;
                    end
                end
            endcase
        end

        n.arready = !n.rvalid;
        n.ist = s.ist & ~ist_clr;
        if (load_req) begin
            // Image is sanitised and written back in place
            n.flags  = s.flags & avail;
            n.active = 1'b1;
            for (int i = 0; i < NUM_EV; i++) begin
                n.intv[i] = clean_intv[i];
                n.ctr[i]  = clean_ctr[i];
                n.cnt[i]  = clean_ctr[i][FIELD_W-1:0];
            end
            n.ist[IST_LOAD] = 1'b1;
        end else if (s.active) begin
            for (int i = 0; i < NUM_EV; i++) begin
                if (ev_in[i] && s.flags[FLG_VAL+i]) begin
                    if (s.cnt[i] == '0) begin
                        hit[i]   = 1'b1;
                        n.cnt[i] = s.intv[i][FIELD_W-1:0];
                    end else begin
                        n.cnt[i] = s.cnt[i] - 1'b1;
                    end
                end
            end
            // Lowest event number gets the record slot this cycle
            for (int i = NUM_EV - 1; i >= 0; i--)
                if (hit[i])
                    sel_id = ID_W'(i + 1);
            rec_fire = |hit;
        end

        if (rec_fire) begin
            n.rec_valid  = 1'b1;
            n.rec_id     = sel_id;
            n.rec_offset = s.head;
            n.rec_ts     = s.flags[FLG_PERF_TIMESTAMP_BIT] ? perf_timestamp_bit_in : '0;
            if (ring_full && !s.flags[FLG_CONTINUOUS_MODE_BIT]) begin
                n.missed = s.missed + 1'b1;
                n.ist[IST_MISS] = 1'b1;
            end else begin
                n.head = next_head;
                if (s.flags[FLG_INT] && thr_hit)
                    n.ist[IST_THRESH] = 1'b1;
            end
        end
        n.irq = |(n.ist & n.imask);
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            s <= '0;
        else
            s <= n;
    end

    assign s_axi_awready  = s.awready;
    assign s_axi_wready   = s.wready;
    assign s_axi_bresp    = s.bresp;
    assign s_axi_bvalid   = s.bvalid;
    assign s_axi_arready  = s.arready;
    assign s_axi_rdata    = s.rdata;
    assign s_axi_rresp    = s.rresp;
    assign s_axi_rvalid   = s.rvalid;
    assign rec_valid_out  = s.rec_valid;
    assign rec_id_out     = s.rec_id;
    assign rec_ts_out     = s.rec_ts;
    assign rec_offset_out = s.rec_offset;
    assign active_out     = s.active;
    assign irq_out        = s.irq;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    vs_neg_zero_a: assert property (
        load_req && s.intv[0][FIELD_SIGN] |=> s.intv[0] == '0)
        else $error("negative value sample interval not zeroed");
    ri_min_clamp_a: assert property (
        load_req && NUM_EV > 1 && (s.intv[1][FIELD_SIGN]
        || s.intv[1][FIELD_W-1:0] < MIN_INTERVAL)
        |=> s.intv[1][FIELD_W-1:0] == MIN_INTERVAL)
        else $error("retired interval not clamped to minimum");
    ctr_neg_zero_a: assert property (
        load_req && s.ctr[0][FIELD_SIGN]
        |=> s.cnt[0] == '0 && s.ctr[0] == '0)
        else $error("negative counter not loaded as zero");
    flags_clean_a: assert property (load_req
        |=> (s.flags & ~avail) == '0 && s.active)
        else $error("unavailable flag bits survive load");
    rec_on_zero_a: assert property (
        s.active && !load_req && ev_in[0] && s.flags[FLG_VAL]
        && s.cnt[0] == '0
        |=> rec_valid_out && rec_id_out == ID_W'(1)
            && s.cnt[0] == $past(s.intv[0][FIELD_W-1:0]))
        else $error("record not stored on counter expiry");
    cnt_down_a: assert property (
        s.active && !load_req && !rec_fire && ev_in[0]
        && s.flags[FLG_VAL] && s.cnt[0] != '0
        |=> s.cnt[0] == $past(s.cnt[0]) - 1'b1 && !rec_valid_out
            && $stable(s.head))
        else $error("counter did not count down");
    sync_full_a: assert property (rec_fire && ring_full
        && !s.flags[FLG_CONTINUOUS_MODE_BIT]
        |=> $stable(s.head) && s.missed == $past(s.missed) + 1'b1)
        else $error("full ring in synchronized mode mishandled");
    continuous_mode_bit_adv_a: assert property (rec_fire && s.flags[FLG_CONTINUOUS_MODE_BIT]
        |=> s.head == $past(next_head))
        else $error("continuous mode did not advance head");
    ts_zero_a: assert property (
        rec_fire && !s.flags[FLG_PERF_TIMESTAMP_BIT] |=> rec_ts_out == '0)
        else $error("timestamp stored while disabled");
    thr_irq_a: assert property (
        rec_fire && s.flags[FLG_INT] && thr_hit && s.imask[IST_THRESH]
        && !(ring_full && !s.flags[FLG_CONTINUOUS_MODE_BIT])
        |=> s.ist[IST_THRESH] && irq_out)
        else $error("threshold interrupt missing");

    load_seen_c: cover property (load_req ##1 s.active);
    record_c:    cover property (rec_fire ##1 rec_valid_out);
    missed_c:    cover property (rec_fire && ring_full && !s.flags[FLG_CONTINUOUS_MODE_BIT]);
    irq_c:       cover property (!irq_out ##1 irq_out);
endmodule : pcb_loader

/* rtl/pcb_pkg.sv */
// Purpose: Shared constants for the profiling control block loader
// Assumes: 32-bit AXI4-Lite register window, byte addresses
// Notes:   Event specifiers sit in pairs (interval, counter) from EVT_BASE
package pcb_pkg;
    localparam int          DATA_W     = 32;
    localparam int          ADDR_W     = 8;
    localparam int          FIELD_W    = 26;
    localparam int          FIELD_SIGN = 25;
    localparam int          ID_W       = 8;

    // Register byte addresses
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_FLAGS    = 8'h04;
    localparam logic [7:0]  A_RSIZE    = 8'h08;
    localparam logic [7:0]  A_TAIL     = 8'h0c;
    localparam logic [7:0]  A_HEAD     = 8'h10;
    localparam logic [7:0]  A_THRESH   = 8'h14;
    localparam logic [7:0]  A_MISS_LO  = 8'h18;
    localparam logic [7:0]  A_MISS_HI  = 8'h1c;
    localparam logic [7:0]  A_ISTAT    = 8'h20;
    localparam logic [7:0]  A_IMASK    = 8'h24;
    localparam logic [7:0]  A_EVT_BASE = 8'h40;
    localparam int          EVT_SHIFT  = 3;
    localparam int          EVT_CTR_B  = 2;

    // Control register bits
    localparam int          CTL_LOAD   = 0;
    localparam int          CTL_SAVE   = 1;
    localparam int          CTL_STOP   = 2;

    // Flags word bits
    localparam int          FLG_VAL    = 1;
    localparam int          FLG_CONTINUOUS_MODE_BIT   = 29;
    localparam int          FLG_PERF_TIMESTAMP_BIT   = 30;
    localparam int          FLG_INT    = 31;

    // Interrupt status bits
    localparam int          IST_W      = 3;
    localparam int          IST_THRESH = 0;
    localparam int          IST_MISS   = 1;
    localparam int          IST_LOAD   = 2;

    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] RECORD_SIZE = 32'h0000_0020;
    localparam logic [25:0] MIN_INTERVAL_DEF = 26'h000_0010;
endpackage : pcb_pkg

/* rtl/pcb_ring.sv */
// Purpose: Ring buffer head advance, full check and fill level compare
// Assumes: Head and tail are below the ring size
// Notes:   Combinational; the caller decides whether the head moves
`timescale 1ns/1ps
module pcb_ring
    import pcb_pkg::*;
(
    input  wire logic [pcb_pkg::DATA_W-1:0] head_in,   // Current head
    input  wire logic [pcb_pkg::DATA_W-1:0] tail_in,   // Software tail
    input  wire logic [pcb_pkg::DATA_W-1:0] size_in,   // Ring size
    input  wire logic [pcb_pkg::DATA_W-1:0] thresh_in, // Fill threshold
    output logic      [pcb_pkg::DATA_W-1:0] head_out,  // Advanced head
    output logic                            full_out,  // Advance hits tail
    output logic                            thresh_out // Fill reaches level
);
    logic [DATA_W:0]   sum;
    logic [DATA_W:0]   used;

    always_comb begin
        sum = {1'b0, head_in} + {1'b0, RECORD_SIZE};
        if (sum >= {1'b0, size_in})
            sum = sum - {1'b0, size_in};
        head_out = sum[DATA_W-1:0];
        full_out = (head_out == tail_in);
        // Used space is head minus tail modulo the ring size
        if (head_out >= tail_in)
            used = {1'b0, head_out} - {1'b0, tail_in};
        else
            used = {1'b0, head_out} + {1'b0, size_in} - {1'b0, tail_in};
        thresh_out = (used >= {1'b0, thresh_in});
    end
endmodule : pcb_ring

/* rtl/pcb_sanitise.sv */
// Purpose: Cleans one interval/counter pair of the control block on load
// Assumes: Raw words straight from the stored control block image
// Notes:   Purely combinational; upper specifier bits come back as zero
`timescale 1ns/1ps
module pcb_sanitise
    import pcb_pkg::*;
#(
    parameter bit IS_VALUE_SAMPLE = 1'b0
) (
    input  wire logic [pcb_pkg::DATA_W-1:0]  interval_in, // Raw interval
    input  wire logic [pcb_pkg::DATA_W-1:0]  counter_in,  // Raw counter
    input  wire logic [pcb_pkg::FIELD_W-1:0] min_in,      // Least interval
    output logic      [pcb_pkg::DATA_W-1:0]  interval_out, // Clean interval
    output logic      [pcb_pkg::DATA_W-1:0]  counter_out   // Clean counter
);
    logic [FIELD_W-1:0] intv;
    logic [FIELD_W-1:0] ctr;

    always_comb begin
        intv = interval_in[FIELD_W-1:0];
        ctr  = counter_in[FIELD_W-1:0];
        if (IS_VALUE_SAMPLE) begin
            if (intv[FIELD_SIGN])
                intv = '0;
        end else if (intv[FIELD_SIGN] || intv < min_in) begin
            intv = min_in;
        end
        if (ctr[FIELD_SIGN])
            ctr = '0;
        interval_out = {{(DATA_W-FIELD_W){1'b0}}, intv};
        counter_out  = {{(DATA_W-FIELD_W){1'b0}}, ctr};
    end
endmodule : pcb_sanitise

/* sim/pcb_ev_src.sv */
// Purpose: Event source and record counter beside the loader
// Assumes: One burst of value sample events per start pulse
// Notes:   Counts every record pulse since reset, including records missed on a full ring
`timescale 1ns/1ps
module pcb_ev_src (
    input  wire logic       ref_clk_in,   // Core clock
    input  wire logic       arst_n_in,    // Async reset
    input  wire logic [7:0] burst_in,     // Events per burst
    input  wire logic       start_in,     // Burst start
    input  wire logic       rec_valid_in, // Record pulse
    output logic            ev_out,       // Event level
    output logic      [7:0] rec_cnt_out   // Records seen
);
    logic [7:0] left;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            left <= 8'h00;
            ev_out <= 1'b0;
            rec_cnt_out <= 8'h00;
        end else begin
            left <= start_in ? burst_in : left - 8'(left != 8'h00);
            ev_out <= !start_in && left != 8'h00;
            rec_cnt_out <= rec_cnt_out + 8'(rec_valid_in);
        end
    end
endmodule : pcb_ev_src

/* sim/pcb_loader_tb_top.sv */
// Purpose: Self-checking bench for the control block loader
// Assumes: Default loader parameters, single clock
// Notes:   Random fields from a fixed seed
`timescale 1ns/1ps
module pcb_loader_tb_top;
import pcb_pkg::*;
logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
logic go = 0, en = 0, awr, wr_, bv, arr, rv, recv, irq, ev, act;
logic [7:0] awa = 0, ara = 0, burst = 0, rid, nrec;
logic [31:0] wd = 0, ts = 0, rd, rdata, rts, roff, img [4];
logic [4:0] evr = 0;
logic [3:0] ws = 4'hf;
logic [1:0] rr, rresp, br;
int n_mismatch = 0, comparisons = 0, seed = 74, i;
pcb_loader pcb_loader_inst (.ref_clk_in(clk), .arst_n_in(rst_n),
  .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
  .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
  .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
  .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
  .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
  .s_axi_rvalid(rv), .s_axi_rready(rry), .ev_in({evr, ev}),
  .perf_timestamp_bit_in(ts), .rec_valid_out(recv), .rec_id_out(rid),
  .rec_ts_out(rts), .rec_offset_out(roff), .active_out(act),
  .irq_out(irq));
pcb_ev_src pcb_ev_src_inst (.ref_clk_in(clk), .arst_n_in(rst_n),
  .burst_in(burst), .start_in(go), .rec_valid_in(recv), .ev_out(ev),
  .rec_cnt_out(nrec));
initial forever #20 clk = ~clk;
always @(posedge clk) evr <= en ? 5'($random(seed)) : 5'h00;
task automatic chk(input logic [31:0] g, input logic [31:0] e);
  comparisons++;
  if (g !== e) begin
    n_mismatch++;
    $display("Error t=%0t got %h exp %h", $time, g, e);
  end
endtask : chk
task automatic wrr(input logic [7:0] a, input logic [31:0] d);
  logic ad, dd;
  ad = 0; dd = 0;
  awa <= a; wd <= d; awv <= 1; wv <= 1;
  while (!(ad && dd)) begin
    @(posedge clk);
    if (awr && !ad) begin ad = 1; awv <= 0; end
    if (wr_ && !dd) begin dd = 1; wv <= 0; end
  end
  bry <= 1;
  do @(posedge clk); while (!bv);
  bry <= 0;
endtask : wrr
task automatic rdr(input logic [7:0] a);
  ara <= a; arv <= 1;
  do @(posedge clk); while (!arr);
  arv <= 0; rry <= 1;
  do @(posedge clk); while (!rv);
  rd = rdata; rr = rresp; rry <= 0;
endtask : rdr
function automatic logic [31:0] san(input logic [31:0] w, input bit vs);
  logic [25:0] s;
  s = w[25:0];
  if (s[25]) s = vs ? 26'h0 : MIN_INTERVAL_DEF;
  else if (!vs && s < MIN_INTERVAL_DEF) s = MIN_INTERVAL_DEF;
  return {6'h00, s};
endfunction : san
task summarize;
  if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
  else $display("TESTS FAILED");
  $finish;
endtask : summarize
initial begin
  repeat (20000) @(posedge clk);
  n_mismatch++;
  summarize;
end
initial begin
  repeat (8) @(posedge clk);
  rst_n <= 1;
  @(posedge clk);
  img[0] = {7'h7f, 25'($random(seed))};
  img[1] = 32'hffff_ffff;
  img[2] = {6'h2a, 22'h0, 4'($random(seed))};
  img[3] = 32'h0300_0000;
  for (i = 0; i < 4; i++) wrr(A_EVT_BASE + 8'(4 * (i + (i > 2))), img[i]);
  wrr(A_FLAGS, 32'hffff_ffff);
  wrr(A_RSIZE, 32'h100);
  wrr(A_CTRL, 32'h1);
  rdr(A_FLAGS); chk(rd, 32'he000_007e);
  rdr(A_EVT_BASE); chk(rd, san(img[0], 1));
  rdr(A_EVT_BASE + 8'h04); chk(rd, 32'h0);
  rdr(A_EVT_BASE + 8'h08); chk(rd, san(img[2], 0));
  rdr(A_EVT_BASE + 8'h10); chk(rd, san(img[3], 0));
  rdr(A_ISTAT); chk(rd, 32'h4);
  wrr(A_IMASK, 32'h4); @(posedge clk); chk(irq, 1);
  wrr(A_ISTAT, 32'h4); @(posedge clk); chk(irq, 0);
  rdr(8'h30); chk(rr, RESP_SLVERR); chk(rd, 0);
  ts <= $random(seed);
  wrr(A_FLAGS, 32'he000_0002); wrr(A_THRESH, 2 * RECORD_SIZE);
  wrr(A_IMASK, 32'h1); wrr(A_EVT_BASE, 32'h2);
  wrr(A_EVT_BASE + 8'h04, 32'h2);
  wrr(A_CTRL, 32'h1); chk(irq, 0);
  en <= 1; burst <= 8'h06; go <= 1;
  @(posedge clk);
  go <= 0;
  repeat (12) @(posedge clk);
  chk(nrec, 2); chk(rid, 1);
  chk(rts, ts); chk(roff, RECORD_SIZE);
  chk(irq, 1);
  wrr(A_CTRL, 32'h4); chk(act, 0);
  rdr(A_HEAD); chk(rd, 2 * RECORD_SIZE);
  wrr(A_FLAGS, 32'h2); wrr(A_TAIL, 3 * RECORD_SIZE);
  wrr(A_CTRL, 32'h1); chk(act, 1);
  burst <= 8'h04; go <= 1;
  @(posedge clk);
  go <= 0;
  repeat (10) @(posedge clk);
  chk(nrec, 3); chk(rts, 0);
  rdr(A_HEAD); chk(rd, 2 * RECORD_SIZE);
  rdr(A_MISS_LO); chk(rd, 1);
  wrr(A_CTRL, 32'h2); rdr(A_EVT_BASE + 8'h04); chk(rd, 1);
  summarize;
end
endmodule : pcb_loader_tb_top
